// [imw_idle_ctrl.sv]
// imw_idle_ctrl: idle mode sequencer with interrupt enable/priority regs.
// assumes irq sources and the watchdog timeout come from mclk logic;
// the core pulses power_save_instruction for one cycle to request idle.
//
// Overview of operation
// - idle stalls cpu execution until a wake event arrives
// - entering idle pulses a watchdog count clear
// - system clock and peripherals keep running during idle
// - per module disable bits may switch peripherals off in idle
// - low power rc oscillator stays on when watchdog or monitor enabled
// - enabled interrupt, device reset or watchdog timeout ends idle
// - cpu clock returns, execution resumes 2 to 4 cycles after wake
// - resume at next instruction, or enter service routine if taken
// - interrupt during instruction held off until idle entry completes
// - three bit priority codes levels 1 to 7, 7 highest
// - priority zero disables the source, no service and no wake
// - external irq3 priority at bits 6-4, resets to level 4
// - pwm priority at bits 6-4, motor variants only, resets to 4
// - unimplemented bits read zero and ignore writes
// - module disable takes effect one instruction cycle later
`timescale 1ns/1ps
module imw_idle_ctrl #(
    parameter bit MOTOR_VARIANT = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        power_save_instruction,
    input  wire logic [4:0]  irq_request,
    input  wire logic        wdt_timeout,
    output logic             cpu_clk_en,
    output logic             cpu_stall,
    output logic             take_isr,
    output logic [2:0]       isr_level,
    output logic             wdt_clear,
    output logic             low_power_rc_oscillator_keep_on,
    output logic             sys_clk_on,
    output logic [7:0]       module_enable,
    output logic             irq
);
    imw_pkg::imw_state_t state_r;
    logic [15:0] enable_r;
    logic [2:0]  pri_ext3_r;
    logic [2:0]  pri_pwm_r;
    logic [2:0]  pri_chg_r;
    logic [15:0] ctrl_r;
    logic [1:0]  ev_stat_r;
    logic [1:0]  ev_mask_r;
    logic [1:0]  resume_cnt_r;
    logic        answered_r;
    logic [4:0]  src_en;
    logic [2:0]  src_pri [5];
    logic [4:0]  src_live;
    logic        wake_irq;
    logic [2:0]  best_pri;
    logic [15:0] wmask;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] rd_nxt;
    logic [15:0] en_mask;

    assign en_mask = MOTOR_VARIANT ? imw_pkg::EN_MASK_FULL
                                   : imw_pkg::EN_MASK_GP;
    assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // one wait cycle per access, so read data is registered
    assign wr_go = clk_en & avs_write & ~answered_r;
    assign rd_go = clk_en & avs_read & ~answered_r;

    // source enables and priorities, one entry per irq line
    assign src_en[imw_pkg::SRC_EXT3] = 1'b1;
    assign src_en[imw_pkg::SRC_PWM]  = MOTOR_VARIANT;
    assign src_en[imw_pkg::SRC_CHG]  = enable_r[imw_pkg::EN_CHG_BIT];
    assign src_en[imw_pkg::SRC_SERR] = enable_r[imw_pkg::EN_SERR_BIT];
    assign src_en[imw_pkg::SRC_FLTB] = enable_r[imw_pkg::EN_FLTB_BIT];
    assign src_pri[imw_pkg::SRC_EXT3] = pri_ext3_r;
    assign src_pri[imw_pkg::SRC_PWM]  = pri_pwm_r;
    assign src_pri[imw_pkg::SRC_CHG]  = pri_chg_r;
    // no own priority field for these, they share level 4
    assign src_pri[imw_pkg::SRC_SERR] = imw_pkg::PRI_RESET;
    assign src_pri[imw_pkg::SRC_FLTB] = imw_pkg::PRI_RESET;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_src
            assign src_live[gi] = irq_request[gi] & src_en[gi]
                                  & (src_pri[gi] != imw_pkg::PRI_OFF);
        end
    endgenerate
    assign wake_irq = |src_live;

    always_comb begin
        best_pri = imw_pkg::PRI_OFF;
        for (int i = 0; i < 5; i++) begin
            if (src_live[i] && (src_pri[i] > best_pri)) begin
                best_pri = src_pri[i];
            end
        end
    end

    // idle sequencer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r      <= imw_pkg::IMW_RUN;
            resume_cnt_r <= 2'h0;
            cpu_clk_en   <= 1'b1;
            cpu_stall    <= 1'b0;
            take_isr     <= 1'b0;
            isr_level    <= 3'h0;
            wdt_clear    <= 1'b0;
        end else if (clk_en) begin
            wdt_clear <= 1'b0;
            take_isr  <= 1'b0;
            case (state_r)
                imw_pkg::IMW_RUN: begin
                    if (power_save_instruction) begin
                        cpu_clk_en <= 1'b0;
                        cpu_stall  <= 1'b1;
                        state_r    <= imw_pkg::IMW_ENTER;
                    end
                end
                imw_pkg::IMW_ENTER: begin
                    wdt_clear <= 1'b1;
                    state_r   <= imw_pkg::IMW_IDLE;
                end
                imw_pkg::IMW_IDLE: begin
                    if (wake_irq || wdt_timeout) begin
                        isr_level    <= wake_irq ? best_pri : 3'h0;
                        resume_cnt_r <= imw_pkg::RESUME_CYCLES;
                        cpu_clk_en   <= 1'b1;
                        state_r      <= imw_pkg::IMW_RESUME;
                    end
                end
                imw_pkg::IMW_RESUME: begin
                    if (resume_cnt_r == 2'h1) begin
                        cpu_stall <= 1'b0;
                        take_isr  <= (isr_level != 3'h0);
                        state_r   <= imw_pkg::IMW_RUN;
                    end
                    resume_cnt_r <= resume_cnt_r - 2'h1;
                end
                default: state_r <= imw_pkg::IMW_RUN;
            endcase
        end
    end

    // clock keepers: system clock never gated here
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sys_clk_on    <= 1'b1;
            low_power_rc_oscillator_keep_on  <= 1'b0;
            module_enable <= 8'hFF;
        end else if (clk_en) begin
            sys_clk_on   <= 1'b1;
            low_power_rc_oscillator_keep_on <= ctrl_r[imw_pkg::CTRL_WDT_BIT]
                            | ctrl_r[imw_pkg::CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT];
            module_enable <= ~ctrl_r[imw_pkg::CTRL_PMD_LSB +: 8];
        end
    end

    // register writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            enable_r   <= 16'h0000;
            pri_ext3_r <= imw_pkg::PRI_RESET;
            pri_pwm_r  <= imw_pkg::PRI_RESET;
            pri_chg_r  <= imw_pkg::PRI_RESET;
            ctrl_r     <= 16'h0000;
            ev_mask_r  <= 2'h0;
        end else if (wr_go) begin
            case (avs_address)
                imw_pkg::OFF_ENABLE:
                    enable_r <= (enable_r & ~(wmask & en_mask))
                              | (avs_writedata[15:0] & wmask & en_mask);
                imw_pkg::OFF_PRI_EXT3:
                    if (avs_byteenable[0]) begin
                        pri_ext3_r <= avs_writedata[6:4];
                    end
                imw_pkg::OFF_PRI_PWM:
                    if (avs_byteenable[0] && MOTOR_VARIANT) begin
                        pri_pwm_r <= avs_writedata[6:4];
                    end
                imw_pkg::OFF_PRI_CHG:
                    if (avs_byteenable[0]) begin
                        pri_chg_r <= avs_writedata[6:4];
                    end
                imw_pkg::OFF_CTRL:
                    ctrl_r <= ((ctrl_r & ~wmask)
                             | (avs_writedata[15:0] & wmask)) & 16'hFF06;
                imw_pkg::OFF_IRQ_MASK:
                    if (avs_byteenable[0]) begin
                        ev_mask_r <= avs_writedata[1:0];
                    end
                default: ;
            endcase
        end
    end

    // sticky events; a read clears, a new event in that cycle wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ev_stat_r <= 2'h0;
        end else if (clk_en) begin
            if (rd_go && avs_address == imw_pkg::OFF_IRQ_STAT) begin
                ev_stat_r <= 2'h0;
            end
            if (state_r == imw_pkg::IMW_ENTER) begin
                ev_stat_r[imw_pkg::EV_ENTER] <= 1'b1;
            end
            if (state_r == imw_pkg::IMW_IDLE && (wake_irq || wdt_timeout)) begin
                ev_stat_r[imw_pkg::EV_WAKE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(ev_stat_r & ev_mask_r);
        end
    end

    // read mux, zero fill
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (avs_address)
            imw_pkg::OFF_ENABLE:   rd_nxt[15:0] = enable_r & en_mask;
            imw_pkg::OFF_PRI_EXT3: rd_nxt[6:4]  = pri_ext3_r;
            imw_pkg::OFF_PRI_PWM:
                rd_nxt[6:4] = MOTOR_VARIANT ? pri_pwm_r : 3'h0;
            imw_pkg::OFF_PRI_CHG:  rd_nxt[6:4]  = pri_chg_r;
            imw_pkg::OFF_CTRL:     rd_nxt[15:0] = ctrl_r;
            imw_pkg::OFF_STATUS:   rd_nxt[3:0]  = state_r;
            imw_pkg::OFF_IRQ_STAT: rd_nxt[1:0]  = ev_stat_r;
            imw_pkg::OFF_IRQ_MASK: rd_nxt[1:0]  = ev_mask_r;
            default:               rd_nxt = 32'h0000_0000;
        endcase
    end

    // bus handshake: waitrequest drops one cycle after the request;
    // kept as a flop beside answered_r so the pin never glitches
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            answered_r      <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (clk_en) begin
            answered_r      <= (avs_read | avs_write) & ~answered_r;
            avs_waitrequest <= ~((avs_read | avs_write) & ~answered_r);
            if (rd_go) begin
                avs_readdata <= rd_nxt;
            end
        end
    end

    // assertions
    // stall held in idle
    stall_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == imw_pkg::IMW_IDLE |-> cpu_stall && !cpu_clk_en)
        else $error("cpu not stalled in idle");
    idle_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && state_r == imw_pkg::IMW_IDLE && !wake_irq && !wdt_timeout
        |=> state_r == imw_pkg::IMW_IDLE)
        else $error("idle left without a wake event");
    wdt_clr_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && state_r == imw_pkg::IMW_ENTER |=> wdt_clear)
        else $error("no watchdog clear on entry");
    clr_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && wdt_clear |=> !wdt_clear)
        else $error("watchdog clear longer than one cycle");
    wake_go_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && state_r == imw_pkg::IMW_IDLE && wdt_timeout
        |=> state_r == imw_pkg::IMW_RESUME)
        else $error("timeout did not wake");
    wake_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && state_r == imw_pkg::IMW_IDLE && wake_irq
        |=> state_r == imw_pkg::IMW_RESUME && cpu_clk_en)
        else $error("enabled irq did not wake");
    resume_dly_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(cpu_clk_en) && clk_en |-> cpu_stall ##1 cpu_stall ##1 1'b1)
        else $error("resume earlier than 2 cycles");
    resume_max_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && $rose(cpu_clk_en) |-> ##[1:3] !cpu_stall)
        else $error("resume later than 4 cycles");
    isr_taken_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && $fell(cpu_stall) |-> take_isr == (isr_level != 3'h0))
        else $error("service routine entry wrong");
    entry_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && state_r == imw_pkg::IMW_ENTER
        |=> state_r == imw_pkg::IMW_IDLE)
        else $error("idle entry not completed");
    level_top_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && state_r == imw_pkg::IMW_IDLE && src_live[imw_pkg::SRC_CHG]
        |=> isr_level >= $past(pri_chg_r))
        else $error("wake level below a live source");
    pri_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        pri_ext3_r == imw_pkg::PRI_OFF |-> !src_live[imw_pkg::SRC_EXT3])
        else $error("disabled source is live");
    ext3_field_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_go && avs_address == imw_pkg::OFF_PRI_EXT3 && avs_byteenable[0]
        |=> pri_ext3_r == $past(avs_writedata[6:4]))
        else $error("ext irq3 priority not written");
    en_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !enable_r[imw_pkg::EN_CHG_BIT] |-> !src_live[imw_pkg::SRC_CHG])
        else $error("disabled charge unit request is live");
    low_power_rc_oscillator_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && ctrl_r[imw_pkg::CTRL_WDT_BIT] |=> low_power_rc_oscillator_keep_on)
        else $error("rc oscillator dropped");
    low_power_rc_oscillator_fail_safe_clock_monitor_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && ctrl_r[imw_pkg::CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT] |=> low_power_rc_oscillator_keep_on)
        else $error("rc oscillator dropped with monitor on");
    pmd_lag_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en |=> module_enable == ~$past(ctrl_r[15:8]))
        else $error("module disable lag wrong");
    unimpl_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (enable_r & ~imw_pkg::EN_MASK_FULL) == 16'h0000)
        else $error("unimplemented enable bit set");
    clk_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == imw_pkg::IMW_IDLE |-> sys_clk_on)
        else $error("system clock off in idle");
    // interrupt follows unmasked events
    irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en |=> irq == |($past(ev_stat_r) & $past(ev_mask_r)))
        else $error("interrupt line wrong");
    // bus answered one cycle after a request
    bus_answer_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clk_en && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus request not answered");
    // sequencer always in one state
    state_hot_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $onehot(state_r))
        else $error("sequencer state not one-hot");
endmodule : imw_idle_ctrl

// [imw_pkg.sv]
// imw_pkg: register map, field layout, reset values and timing of the
// idle mode and interrupt wake controller.
// assumes a 32-bit avalon-mm slave with word addressing in byte units.
package imw_pkg;
    // register byte offsets
    localparam logic [4:0] OFF_ENABLE   = 5'h00;
    localparam logic [4:0] OFF_PRI_EXT3 = 5'h04;
    localparam logic [4:0] OFF_PRI_PWM  = 5'h08;
    localparam logic [4:0] OFF_PRI_CHG  = 5'h0C;
    localparam logic [4:0] OFF_CTRL     = 5'h10;
    localparam logic [4:0] OFF_STATUS   = 5'h14;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h18;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h1C;
    // enable register fields
    localparam int EN_CHG_BIT   = 13;
    localparam int EN_SERR_BIT  = 1;
    localparam int EN_FLTB_BIT  = 0;
    // priority field position
    localparam int PRI_LSB      = 4;
    localparam int PRI_MSB      = 6;
    localparam logic [2:0] PRI_RESET = 3'h4;
    localparam logic [2:0] PRI_OFF   = 3'h0;
    // control register fields
    localparam int CTRL_IDLE_BIT = 0;
    localparam int CTRL_WDT_BIT  = 1;
    localparam int CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT = 2;
    localparam int CTRL_PMD_LSB  = 8;
    localparam int NUM_PMD       = 8;
    localparam int NUM_SRC       = 6;
    // source index order
    localparam int SRC_EXT3 = 0;
    localparam int SRC_PWM  = 1;
    localparam int SRC_CHG  = 2;
    localparam int SRC_SERR = 3;
    localparam int SRC_FLTB = 4;
    localparam int SRC_WDT  = 5;
    // cpu clock resume delay, within the 2 to 4 cycle window
    localparam logic [1:0] RESUME_CYCLES = 2'h3;
    // event status bits
    localparam int EV_ENTER = 0;
    localparam int EV_WAKE  = 1;
    localparam logic [15:0] EN_MASK_FULL = 16'h2003;
    localparam logic [15:0] EN_MASK_GP   = 16'h2002;
    typedef enum logic [3:0] {
        IMW_RUN    = 4'b0001,
        IMW_ENTER  = 4'b0010,
        IMW_IDLE   = 4'b0100,
        IMW_RESUME = 4'b1000
    } imw_state_t;
endpackage : imw_pkg

// [imw_core_model.sv]
// imw_core_model: stand-in for the core and the interrupt sources.
// assumes the bench calls its tasks from mclk-aligned code.
`timescale 1ns/1ps
module imw_core_model (
    input  wire logic       mclk,
    input  wire logic       take_isr,
    output logic            power_save_instruction,
    output logic [4:0]      irq_request,
    output logic            wdt_timeout
);
    // idle sources at time zero
    initial begin
        power_save_instruction = 1'b0;
        irq_request = 5'h00;
        wdt_timeout = 1'b0;
    end
    // entering the service routine clears every pending source
    always @(posedge mclk) begin
        if (take_isr === 1'b1) irq_request <= 5'h00;
    end
    // request may coincide with the instruction
    task automatic exec_psi(input logic [4:0] with_irq);
        @(posedge mclk);
        power_save_instruction <= 1'b1;
        irq_request <= irq_request | with_irq;
        @(posedge mclk);
        power_save_instruction <= 1'b0;
    endtask : exec_psi
    // level request held until serviced or dropped
    task automatic set_irq(input logic [4:0] src);
        @(posedge mclk);
        irq_request <= src;
    endtask : set_irq
    // one-cycle timeout pulse, rarely seen in practice
    task automatic wdt_fire();
        @(posedge mclk);
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
    endtask : wdt_fire
endmodule : imw_core_model

// [imw_idle_ctrl_test.sv]
// imw_idle_ctrl_test: register, idle entry and wake checks.
// assumes imw_core_model drives the core and interrupt side.
`timescale 1ns/1ps
module imw_idle_ctrl_test;
    logic        mclk, rst_b, clk_en, avs_read, avs_write;
    logic [4:0]  avs_address, irq_request;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest, power_save_instruction, wdt_timeout;
    logic        cpu_clk_en, cpu_stall, take_isr, wdt_clear, irq;
    logic        low_power_rc_oscillator_keep_on, sys_clk_on;
    logic [2:0]  isr_level;
    logic [7:0]  module_enable;
    int          fail_count = 0;
    int          check_count = 0;
    imw_idle_ctrl imw_idle_ctrl_inst (.mclk(mclk), .rst_b(rst_b),
        .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .power_save_instruction(power_save_instruction),
        .irq_request(irq_request), .wdt_timeout(wdt_timeout),
        .cpu_clk_en(cpu_clk_en), .cpu_stall(cpu_stall),
        .take_isr(take_isr), .isr_level(isr_level), .wdt_clear(wdt_clear),
        .low_power_rc_oscillator_keep_on(low_power_rc_oscillator_keep_on), .sys_clk_on(sys_clk_on),
        .module_enable(module_enable), .irq(irq));
    imw_core_model imw_core_model_inst (.mclk(mclk), .take_isr(take_isr),
        .power_save_instruction(power_save_instruction),
        .irq_request(irq_request), .wdt_timeout(wdt_timeout));
    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // waitrequest sampled at the rising edge, as the master sees it
    task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            close_out();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic enter_idle(logic [4:0] with_irq);
        logic seen = 1'b0;
        imw_core_model_inst.exec_psi(with_irq);
        @(negedge mclk);
        check("stall", 1, cpu_stall);
        check("cpu clock", 0, cpu_clk_en);
        repeat (3) begin
            @(negedge mclk);
            if (wdt_clear === 1'b1) seen = 1'b1;
        end
        check("wdt clear", 1, seen);
        check("sys clock", 1, sys_clk_on);
    endtask : enter_idle
    // resume delay counted from clock return to end of stall
    task automatic await_wake(logic [2:0] lvl, logic interrupt_service_routine);
        int n = 0;
        int on_at = -1;
        logic took = 1'b0;
        while (cpu_stall !== 1'b0 && n < 40) begin
            @(negedge mclk);
            n++;
            if (cpu_clk_en === 1'b1 && on_at < 0) on_at = n;
            if (take_isr === 1'b1) took = 1'b1;
        end
        check("woke", 1, n < 40 && on_at > 0);
        if (n >= 40) close_out();
        check("resume gap", 1, n - on_at <= 4);
        check("take isr", interrupt_service_routine, took);
        if (interrupt_service_routine) check("isr level", lvl, isr_level);
    endtask : await_wake
    task automatic t_reset();
        logic [31:0] exp [6] = '{32'h0, 32'h40, 32'h40, 32'h40, 32'h0,
                                 32'h1};
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 5'(4 * i), 32'h0);
            check("reset value", exp[i], q);
        end
        check("modules", 8'hFF, module_enable);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs();
        logic [31:0] exp [4] = '{32'h2003, 32'h70, 32'h70, 32'h70};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 5'(4 * i), 32'hFFFFFFFF);
            bus(1'b0, 5'(4 * i), 32'h0);
            check("readback", exp[i], q);
        end
        $display("test regs done");
    endtask : t_regs
    task automatic t_modules();
        bus(1'b1, 5'h10, 32'h0000A506);
        repeat (2) @(negedge mclk);
        check("modules off", 8'h5A, module_enable);
        check("low_power_rc_oscillator on", 1, low_power_rc_oscillator_keep_on);
        bus(1'b1, 5'h10, 32'h0);
        repeat (2) @(negedge mclk);
        check("modules on", 8'hFF, module_enable);
        check("low_power_rc_oscillator off", 0, low_power_rc_oscillator_keep_on);
        $display("test modules done");
    endtask : t_modules
    task automatic t_wake();
        bus(1'b1, 5'h04, 32'h50);
        enter_idle(5'h00);
        imw_core_model_inst.set_irq(5'h01);
        await_wake(3'h5, 1'b1);
        bus(1'b1, 5'h04, 32'h0);
        enter_idle(5'h00);
        imw_core_model_inst.set_irq(5'h01);
        repeat (20) @(negedge mclk);
        check("no wake", 1, cpu_stall);
        imw_core_model_inst.set_irq(5'h00);
        imw_core_model_inst.wdt_fire();
        await_wake(3'h0, 1'b0);
        enter_idle(5'h04);
        await_wake(3'h7, 1'b1);
        $display("test wake done");
    endtask : t_wake
    task automatic t_events();
        check("masked irq", 0, irq);
        bus(1'b1, 5'h1C, 32'h3);
        repeat (2) @(negedge mclk);
        check("irq high", 1, irq);
        bus(1'b0, 5'h18, 32'h0);
        check("events", 32'h3, q);
        repeat (2) @(negedge mclk);
        check("irq low", 0, irq);
        bus(1'b0, 5'h18, 32'h0);
        check("events cleared", 32'h0, q);
        $display("test events done");
    endtask : t_events
    // frozen clock enable ignores a timeout; a device reset wakes
    task automatic t_freeze_reset();
        enter_idle(5'h00);
        @(posedge mclk);
        clk_en <= 1'b0;
        imw_core_model_inst.wdt_fire();
        repeat (6) @(negedge mclk);
        check("frozen", 1, cpu_stall);
        @(posedge mclk);
        clk_en <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(negedge mclk);
        check("reset wake", 1, cpu_clk_en & ~cpu_stall);
        @(posedge mclk);
        rst_b <= 1'b1;
        bus(1'b0, 5'h14, 32'h0);
        check("status run", 1, q);
        $display("test freeze reset done");
    endtask : t_freeze_reset
    // reset for five cycles, then every test in turn
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h3;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_modules();
        t_wake();
        t_events();
        t_freeze_reset();
        close_out();
    end
endmodule : imw_idle_ctrl_test
